/* design/sdh_dce.sv */
// modem end: request/clear handshake, bit clocks, serial data both ways
// assumes link inputs come from the host end and are synchronised here
// Notes on behaviour
// - request low keeps modem transmitting host data
// - host requests, then waits for clear
// - request falling starts receive-to-transmit switch
// - clear asserted once transmit path ready
// - full duplex: request and clear held low
// - request rising: finish data, then receive
// - transmit bit clock at bit rate, 50%
// - transmit clock rise at transmit bit centre
// - receive bit clock at bit rate, 50%
// - receive clock rise at receive bit centre
// - host clocks receive logic from receive clock
// - host idles transmit data high
// - receive data high idle and after request rises
// - clear high from off-hook until carrier, except in full duplex, where clear is held low
`timescale 1ns/10ps
`default_nettype none
module sdh_dce #(
   parameter int unsigned HALF_BIT = sdh_pkg::HALF_BIT_CYC,
   parameter int unsigned TURN_ON = sdh_pkg::TURN_ON_CYC,
   parameter int unsigned TAIL = sdh_pkg::TAIL_BITS,
   parameter int unsigned DATA_W = sdh_pkg::DATA_W,
   parameter int unsigned DEPTH = sdh_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic srst_i,
   // line-side control
   input wire logic full_duplex_i,
   input wire logic off_hook_i,
   input wire logic carrier_i,
   // data received from host, bound for the line
   output logic line_tx_valid_o,
   input wire logic line_tx_ready_i,
   output logic [DATA_W-1:0] line_tx_data_o,
   // data from the line, bound for the host
   input wire logic line_rx_valid_i,
   output logic line_rx_ready_o,
   input wire logic [DATA_W-1:0] line_rx_data_i,
   // status
   output logic tx_mode_o,
   // link
   sdh_link_if.dce link
);
   localparam int unsigned HW = $clog2(HALF_BIT + 1) + 1;
   localparam int unsigned TW = $clog2(TURN_ON + 1) + 1;
   localparam int unsigned BW = $clog2(DATA_W + 2);

   sdh_pkg::sdh_mode_t mode_r;
   logic [1:0] rts_s_r;
   logic [1:0] txd_s_r;
   logic rts_d_r;
   logic [HW-1:0] half_r;
   logic clk_r;
   logic rise;
   logic fall;
   logic [TW-1:0] turn_r;
   logic [BW-1:0] tx_bits_r;
   logic [DATA_W-1:0] tx_sh_r;
   logic [BW-1:0] rx_bits_r;
   logic [DATA_W-1:0] rx_sh_r;
   logic rxd_r;
   logic [7:0] tail_r;
   logic cts_r;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic rts_low;
   logic rx_open;

   // two-stage synchronisers
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         rts_s_r <= 2'h3;
         txd_s_r <= 2'h3;
         rts_d_r <= 1'b1;
      end else begin
         rts_s_r <= {rts_s_r[0], link.rts_n};
         txd_s_r <= {txd_s_r[0], link.txd_n};
         rts_d_r <= rts_s_r[1];
      end
   end
   assign rts_low = !rts_s_r[1] || full_duplex_i;

   // shared bit clock divider: even halves give exact 50 percent duty
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         half_r <= '0;
         clk_r <= 1'b1;
      end else if (half_r == HW'(HALF_BIT - 1)) begin
         half_r <= '0;
         clk_r <= !clk_r;
      end else begin
         half_r <= half_r + 1'b1;
      end
   end
   assign rise = (half_r == HW'(HALF_BIT - 1)) && !clk_r;
   assign fall = (half_r == HW'(HALF_BIT - 1)) && clk_r;
   assign link.tx_bit_clock_n = clk_r;
   assign link.rx_bit_clock_n = clk_r;

   // mode sequencing
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         mode_r <= sdh_pkg::SDH_RX;
         turn_r <= '0;
      end else begin
         case (mode_r)
            sdh_pkg::SDH_RX: begin
               if (rts_low) begin
                  mode_r <= sdh_pkg::SDH_TURN_ON;
                  turn_r <= '0;
               end
            end
            sdh_pkg::SDH_TURN_ON: begin
               if (!rts_low) begin
                  mode_r <= sdh_pkg::SDH_RX;
               end else if (full_duplex_i || turn_r == TW'(TURN_ON - 1)) begin
                  mode_r <= sdh_pkg::SDH_TX;
               end else begin
                  turn_r <= turn_r + 1'b1;
               end
            end
            sdh_pkg::SDH_TX: begin
               if (!rts_low) begin
                  mode_r <= sdh_pkg::SDH_DRAIN;
               end
            end
            sdh_pkg::SDH_DRAIN: begin
               if (rts_low) begin
                  mode_r <= sdh_pkg::SDH_TX;
               end else if (tx_bits_r == '0 && !line_tx_valid_o) begin
                  mode_r <= sdh_pkg::SDH_RX;
               end
            end
            default: mode_r <= sdh_pkg::SDH_RX;
         endcase
      end
   end
   assign tx_mode_o = (mode_r == sdh_pkg::SDH_TX) || (mode_r == sdh_pkg::SDH_DRAIN);

   // clear to send
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         cts_r <= 1'b1;
      end else if (full_duplex_i) begin
         cts_r <= 1'b0;
      end else if (off_hook_i && !carrier_i) begin
         cts_r <= 1'b1;
      end else begin
         cts_r <= !(mode_r == sdh_pkg::SDH_TX && fifo_in_ready);
      end
   end
   assign link.cts_n = cts_r;
   assign link.carrier_detect_n = !carrier_i;

   // transmit data: sample synchronised line at clock rise, bit centre
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         tx_bits_r <= '0;
         tx_sh_r <= '0;
      end else if (rise && tx_mode_o) begin
         if (tx_bits_r == '0 && txd_s_r[1]) begin
            tx_bits_r <= '0;
         end else if (tx_bits_r == BW'(DATA_W + 1)) begin
            tx_bits_r <= txd_s_r[1] ? '0 : BW'(1);
            tx_sh_r <= {!txd_s_r[1], tx_sh_r[DATA_W-1:1]};
         end else begin
            tx_bits_r <= tx_bits_r + 1'b1;
            tx_sh_r <= {!txd_s_r[1], tx_sh_r[DATA_W-1:1]};
         end
      end else if (fifo_in_valid && fifo_in_ready) begin
         tx_bits_r <= '0;
      end
   end
   // first low bit acts as start marker and is shifted out
   assign fifo_in_valid = (tx_bits_r == BW'(DATA_W + 1));

   sdh_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(DEPTH)
   ) u_tx_fifo (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .in_valid_i(fifo_in_valid),
      .in_ready_o(fifo_in_ready),
      .in_data_i(tx_sh_r),
      .out_valid_o(line_tx_valid_o),
      .out_ready_i(line_tx_ready_i),
      .out_data_o(line_tx_data_o)
   );

   // mark tail after request rises, counted in bit clock falls
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         tail_r <= '0;
      end else if (rts_d_r == 1'b0 && rts_s_r[1] == 1'b1 && !full_duplex_i) begin
         tail_r <= 8'(TAIL);
      end else if (fall && tail_r != '0) begin
         tail_r <= tail_r - 1'b1;
      end
   end
   // full duplex receives while transmitting
   assign rx_open = (full_duplex_i || !tx_mode_o) && tail_r == '0;

   // receive data: change on clock fall so rise lands mid bit
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         rx_bits_r <= '0;
         rx_sh_r <= '0;
         rxd_r <= 1'b1;
      end else if (fall) begin
         if (rx_bits_r != '0) begin
            rxd_r <= rx_sh_r[0];
            rx_sh_r <= {1'b0, rx_sh_r[DATA_W-1:1]};
            rx_bits_r <= rx_bits_r - 1'b1;
         end else if (line_rx_valid_i && rx_open) begin
            rxd_r <= 1'b0;
            rx_sh_r <= ~line_rx_data_i;
            rx_bits_r <= BW'(DATA_W);
         end else begin
            rxd_r <= 1'b1;
         end
      end
   end
   assign line_rx_ready_o = fall && rx_bits_r == '0 && rx_open;
   assign link.rxd_n = rxd_r;
endmodule : sdh_dce
`default_nettype wire

/* pkg/sdh_pkg.sv */
// package for the synchronous serial handshake, both ends
// assumes a 20 MHz system clock on both ends
package sdh_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned BIT_RATE_HZ = 2400;
   // half of one bit period in system clocks
   localparam int unsigned HALF_BIT_CYC = CLK_HZ / (2 * BIT_RATE_HZ);
   // modem turnaround from receive to transmit, in microseconds
   localparam int unsigned TURN_ON_US = 200;
   localparam int unsigned TURN_ON_CYC = (TURN_ON_US * (CLK_HZ / 1000000) > 0) ?
      TURN_ON_US * (CLK_HZ / 1000000) : 1;
   // receive data held at mark after the request rises, in bit times
   localparam int unsigned TAIL_BITS = 2;
   localparam int unsigned FIFO_DEPTH = 4;
   localparam int unsigned DATA_W = 8;
   typedef enum logic [1:0] {
      SDH_RX,
      SDH_TURN_ON,
      SDH_TX,
      SDH_DRAIN
   } sdh_mode_t;
endpackage : sdh_pkg

/* pkg/sdh_link_if.sv */
// interface carrying the serial link between the modem end and the host end
// assumes both ends are clocked by the same system clock
`timescale 1ns/10ps
`default_nettype none
interface sdh_link_if;
   logic txd_n;
   logic rxd_n;
   logic rts_n;
   logic cts_n;
   logic carrier_detect_n;
   logic tx_bit_clock_n;
   logic rx_bit_clock_n;
   modport dce (
      input txd_n,
      input rts_n,
      output rxd_n,
      output cts_n,
      output carrier_detect_n,
      output tx_bit_clock_n,
      output rx_bit_clock_n
   );
   modport dte (
      output txd_n,
      output rts_n,
      input rxd_n,
      input cts_n,
      input carrier_detect_n,
      input tx_bit_clock_n,
      input rx_bit_clock_n
   );
endinterface : sdh_link_if
`default_nettype wire

/* design/sdh_fifo.sv */
// small flip-flop FIFO with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module sdh_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 4
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic srst_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;

   assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_r != '0);
   assign out_data_o = mem_r[rd_r];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge clock_i) begin
      if (push) begin
         mem_r[wr_r] <= in_data_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule : sdh_fifo
`default_nettype wire

/* design/sdh_dte.sv */
// host end: raises requests, sends and receives bits on modem clocks
// assumes modem supplies both bit clocks; all link inputs synchronised
`timescale 1ns/10ps
`default_nettype none
module sdh_dte #(
   parameter int unsigned DATA_W = sdh_pkg::DATA_W
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic srst_i,
   // data to send
   input wire logic send_valid_i,
   output logic send_ready_o,
   input wire logic [DATA_W-1:0] send_data_i,
   // data received
   output logic recv_valid_o,
   output logic [DATA_W-1:0] recv_data_o,
   // status
   output logic carrier_o,
   // link
   sdh_link_if.dte link
);
   localparam int unsigned BW = $clog2(DATA_W + 2);
   logic [1:0] cts_s_r;
   logic [1:0] rxd_s_r;
   logic [1:0] tck_s_r;
   logic [1:0] rck_s_r;
   logic [1:0] cd_s_r;
   logic tck_d_r;
   logic rck_d_r;
   logic rts_r;
   logic txd_r;
   logic [DATA_W:0] tx_sh_r;
   logic [BW-1:0] tx_bits_r;
   logic [BW-1:0] rx_bits_r;
   logic [DATA_W-1:0] rx_sh_r;
   logic tck_fall;
   logic rck_rise;

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         cts_s_r <= 2'h3;
         rxd_s_r <= 2'h3;
         tck_s_r <= 2'h3;
         rck_s_r <= 2'h3;
         cd_s_r <= 2'h3;
         tck_d_r <= 1'b1;
         rck_d_r <= 1'b1;
      end else begin
         cts_s_r <= {cts_s_r[0], link.cts_n};
         rxd_s_r <= {rxd_s_r[0], link.rxd_n};
         tck_s_r <= {tck_s_r[0], link.tx_bit_clock_n};
         rck_s_r <= {rck_s_r[0], link.rx_bit_clock_n};
         cd_s_r <= {cd_s_r[0], link.carrier_detect_n};
         tck_d_r <= tck_s_r[1];
         rck_d_r <= rck_s_r[1];
      end
   end
   assign tck_fall = tck_d_r && !tck_s_r[1];
   assign rck_rise = !rck_d_r && rck_s_r[1];
   assign carrier_o = !cd_s_r[1];

   // request held low while data waits or a frame is in flight
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         rts_r <= 1'b1;
      end else begin
         rts_r <= !(send_valid_i || tx_bits_r != '0);
      end
   end
   assign link.rts_n = rts_r;

   // start bit then data, launched on clock fall
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         txd_r <= 1'b1;
         tx_bits_r <= '0;
         tx_sh_r <= '0;
      end else if (tck_fall) begin
         if (tx_bits_r != '0) begin
            txd_r <= tx_sh_r[0];
            tx_sh_r <= {1'b1, tx_sh_r[DATA_W:1]};
            tx_bits_r <= tx_bits_r - 1'b1;
         end else if (send_valid_i && !cts_s_r[1] && !rts_r) begin
            txd_r <= 1'b0;
            tx_sh_r <= {1'b1, ~send_data_i};
            tx_bits_r <= BW'(DATA_W);
         end else begin
            txd_r <= 1'b1;
         end
      end
   end
   assign send_ready_o = tck_fall && tx_bits_r == '0 && !cts_s_r[1] && !rts_r;
   assign link.txd_n = txd_r;

   // receive clocked by modem receive clock rises
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         rx_bits_r <= '0;
         rx_sh_r <= '0;
         recv_valid_o <= 1'b0;
         recv_data_o <= '0;
      end else begin
         recv_valid_o <= 1'b0;
         if (rck_rise) begin
            if (rx_bits_r == '0) begin
               if (!rxd_s_r[1]) begin
                  rx_bits_r <= BW'(DATA_W);
               end
            end else begin
               rx_sh_r <= {!rxd_s_r[1], rx_sh_r[DATA_W-1:1]};
               rx_bits_r <= rx_bits_r - 1'b1;
               if (rx_bits_r == BW'(1)) begin
                  recv_valid_o <= 1'b1;
                  recv_data_o <= {!rxd_s_r[1], rx_sh_r[DATA_W-1:1]};
               end
            end
         end
      end
   end
endmodule : sdh_dte
`default_nettype wire

/* sim/sdh_link_checker.sv */
// checker for the serial link joining the modem end and the host end
// assumes one system clock for both ends and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module sdh_link_checker #(
   parameter int unsigned HALF_BIT = 4
) (
   // clock, reset and modem controls
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic full_duplex_i,
   input wire logic off_hook_i,
   input wire logic carrier_i,
   // link
   input wire logic txd_n,
   input wire logic rxd_n,
   input wire logic rts_n,
   input wire logic cts_n,
   input wire logic tx_bit_clock_n,
   input wire logic rx_bit_clock_n
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (srst_i);
   logic tck_q;
   logic armed_r;
   logic [15:0] run_r;
   always_ff @(posedge clock_i) begin
      tck_q <= tx_bit_clock_n;
   end
   // first edge after reset may come late, so arm on it
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         armed_r <= 1'b0;
      end else if (tx_bit_clock_n != tck_q) begin
         armed_r <= 1'b1;
      end
   end
   always_ff @(posedge clock_i) begin
      if (tx_bit_clock_n != tck_q) begin
         run_r <= 16'h0001;
      end else begin
         run_r <= run_r + 16'h0001;
      end
   end
   sequence s_mark8;
      rxd_n [*8];
   endsequence
   sequence s_tail;
      s_mark8 ##1 s_mark8 ##1 rxd_n;
   endsequence
   sequence s_turn_wait;
      cts_n [*8] ##1 cts_n [*2] ##[1:8] !cts_n;
   endsequence
   a_reset_idle: assert property ($fell(srst_i) |-> rts_n && cts_n && txd_n && rxd_n && tx_bit_clock_n)
      else $error("link not idle after reset");
   a_tx_clk_half: assert property (armed_r && (tx_bit_clock_n != tck_q) |-> run_r == HALF_BIT)
      else $error("transmit bit clock half period wrong");
   a_rx_clk_pair: assert property (rx_bit_clock_n == tx_bit_clock_n)
      else $error("receive bit clock off rate");
   a_txd_bit_centre: assert property ($rose(tx_bit_clock_n) |-> ##1 $stable(txd_n) [*3])
      else $error("transmit data moves near clock rise");
   a_rxd_bit_centre: assert property ($rose(rx_bit_clock_n) |-> $stable(rxd_n) [*4])
      else $error("receive data moves near clock rise");
   a_cts_turn_on: assert property ($fell(rts_n) && !full_duplex_i && !off_hook_i |-> s_turn_wait)
      else $error("clear timing after request wrong");
   a_cts_release: assert property ($rose(rts_n) && !full_duplex_i |-> ##[1:6] cts_n)
      else $error("clear not withdrawn after request");
   a_rxd_tail_mark: assert property ($rose(rts_n) && !full_duplex_i |-> s_tail)
      else $error("receive data not mark after request");
   a_hook_holds_cts: assert property ((off_hook_i && !carrier_i) [*3] |-> cts_n)
      else $error("clear low while off hook without carrier");
   a_duplex_clear: assert property (full_duplex_i [*8] ##0 !(off_hook_i && !carrier_i) |-> !cts_n)
      else $error("clear not low in full duplex");
endmodule : sdh_link_checker
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench: modem end and host end joined by the link interface
// assumes shortened bit and turn-on counts on the modem end
`timescale 1ns/10ps
`default_nettype none
module testbench;
   typedef struct packed {
      logic [7:0] din;
      logic [7:0] dout;
   } sdh_row_t;
   localparam int unsigned HB = 8;
   localparam sdh_row_t ROWS [6] = '{'{8'h00, 8'h00}, '{8'hFF, 8'hFF}, '{8'hA5, 8'hA5},
      '{8'h5A, 8'h5A}, '{8'h01, 8'h01}, '{8'h80, 8'h80}};
   logic clock_i = 1'b0;
   logic srst_i = 1'b1;
   logic full_duplex_i = 1'b0;
   logic off_hook_i = 1'b0;
   logic carrier_i = 1'b1;
   logic line_tx_ready_i = 1'b1;
   logic line_rx_valid_i = 1'b0;
   logic [7:0] line_rx_data_i = 8'h00;
   logic send_valid_i = 1'b0;
   logic [7:0] send_data_i = 8'h00;
   logic line_tx_valid_o;
   logic line_rx_ready_o;
   logic tx_mode_o;
   logic send_ready_o;
   logic recv_valid_o;
   logic carrier_o;
   logic [7:0] line_tx_data_o;
   logic [7:0] recv_data_o;
   logic [7:0] got_tx[$];
   logic [7:0] got_rx[$];
   int miscompares = 0;
   int cmp_count = 0;
   always #25 clock_i = ~clock_i;
   sdh_link_if link ();
   sdh_dce #(.HALF_BIT(HB), .TURN_ON(8)) u_sdh_dce (.clock_i, .srst_i, .full_duplex_i, .off_hook_i,
      .carrier_i, .line_tx_valid_o, .line_tx_ready_i, .line_tx_data_o, .line_rx_valid_i,
      .line_rx_ready_o, .line_rx_data_i, .tx_mode_o, .link(link));
   sdh_dte u_sdh_dte (.clock_i, .srst_i, .send_valid_i, .send_ready_o, .send_data_i, .recv_valid_o,
      .recv_data_o, .carrier_o, .link(link));
   sdh_link_checker #(.HALF_BIT(HB)) u_sdh_link_checker (.clock_i, .srst_i, .full_duplex_i,
      .off_hook_i, .carrier_i, .txd_n(link.txd_n), .rxd_n(link.rxd_n), .rts_n(link.rts_n),
      .cts_n(link.cts_n), .tx_bit_clock_n(link.tx_bit_clock_n), .rx_bit_clock_n(link.rx_bit_clock_n));
   // collect delivered bytes where the handshakes have settled
   always @(negedge clock_i) begin
      if (line_tx_valid_o === 1'b1 && line_tx_ready_i) begin
         got_tx.push_back(line_tx_data_o);
      end
      if (recv_valid_o === 1'b1) begin
         got_rx.push_back(recv_data_o);
      end
   end
   task automatic summarize();
      $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize
   task automatic timeout(input int got, input int exp);
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      summarize();
   endtask : timeout
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_byte
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_bit
   // one byte into the host end, or into the modem end from the line
   task automatic push(input bit from_line, input logic [7:0] d);
      int i;
      @(posedge clock_i);
      if (from_line) begin
         line_rx_valid_i <= 1'b1;
         line_rx_data_i <= d;
      end else begin
         send_valid_i <= 1'b1;
         send_data_i <= d;
      end
      for (i = 0; i < 4000; i++) begin
         @(negedge clock_i);
         if ((from_line ? line_rx_ready_o : send_ready_o) === 1'b1) break;
      end
      @(posedge clock_i);
      if (from_line) begin
         line_rx_valid_i <= 1'b0;
      end else begin
         send_valid_i <= 1'b0;
      end
      if (i == 4000) timeout(i, d);
   endtask : push
   task automatic wait_count(input bit is_rx, input int n);
      int i;
      for (i = 0; i < 4000; i++) begin
         if ((is_rx ? got_rx.size() : got_tx.size()) >= n) return;
         @(negedge clock_i);
      end
      timeout(is_rx ? got_rx.size() : got_tx.size(), n);
   endtask : wait_count
   initial begin
      int k;
      repeat (5) @(posedge clock_i);
      srst_i <= 1'b0;
      for (k = 0; k < 6; k++) begin
         push(1'b0, ROWS[k].din);
      end
      wait_count(1'b0, 6);
      for (k = 0; k < 6; k++) begin
         cmp_byte(got_tx[k], ROWS[k].dout);
      end
      for (k = 0; k < 6; k++) begin
         push(1'b1, ROWS[k].din);
      end
      wait_count(1'b1, 6);
      for (k = 0; k < 6; k++) begin
         cmp_byte(got_rx[k], ROWS[k].dout);
      end
      // off hook without carrier keeps the host waiting
      got_tx.delete();
      @(posedge clock_i);
      off_hook_i <= 1'b1;
      carrier_i <= 1'b0;
      fork
         push(1'b0, 8'hC3);
      join_none
      repeat (200) @(posedge clock_i);
      @(negedge clock_i);
      cmp_bit(link.cts_n, 1'b1);
      cmp_bit(carrier_o, 1'b0);
      cmp_bit(link.txd_n, 1'b1);
      @(posedge clock_i);
      carrier_i <= 1'b1;
      wait_count(1'b0, 1);
      cmp_byte(got_tx[0], 8'hC3);
      @(posedge clock_i);
      off_hook_i <= 1'b0;
      // fill the buffer with the line stalled, fifth byte refused
      got_tx.delete();
      line_tx_ready_i <= 1'b0;
      for (k = 0; k < 4; k++) begin
         push(1'b0, ROWS[k].din);
      end
      fork
         push(1'b0, ROWS[4].din);
      join_none
      repeat (300) @(posedge clock_i);
      @(negedge clock_i);
      cmp_bit(link.rts_n, 1'b0);
      cmp_bit(link.cts_n, 1'b1);
      @(posedge clock_i);
      line_tx_ready_i <= 1'b1;
      wait_count(1'b0, 5);
      for (k = 0; k < 5; k++) begin
         cmp_byte(got_tx[k], ROWS[k].dout);
      end
      // full duplex: both directions at once
      got_tx.delete();
      got_rx.delete();
      @(posedge clock_i);
      full_duplex_i <= 1'b1;
      repeat (50) @(posedge clock_i);
      @(negedge clock_i);
      cmp_bit(link.cts_n, 1'b0);
      fork
         push(1'b0, 8'h3C);
         push(1'b1, 8'hE7);
      join
      wait_count(1'b0, 1);
      wait_count(1'b1, 1);
      cmp_byte(got_tx[0], 8'h3C);
      cmp_byte(got_rx[0], 8'hE7);
      @(posedge clock_i);
      full_duplex_i <= 1'b0;
      // reset in mid frame, then recover
      repeat (100) @(posedge clock_i);
      push(1'b1, 8'h96);
      repeat (30) @(posedge clock_i);
      srst_i <= 1'b1;
      repeat (5) @(posedge clock_i);
      @(negedge clock_i);
      cmp_bit(link.rxd_n, 1'b1);
      cmp_bit(link.cts_n, 1'b1);
      cmp_bit(recv_valid_o, 1'b0);
      got_tx.delete();
      @(posedge clock_i);
      srst_i <= 1'b0;
      push(1'b0, 8'h69);
      wait_count(1'b0, 1);
      cmp_byte(got_tx[0], 8'h69);
      summarize();
   end
endmodule : testbench
`default_nettype wire
